// ==== pll_divider_lock_control.sv ====
// reference divider, fixed LO divider, tri-state phase detector, lock detector, control decoder
// assumes pins arrive asynchronous to clk; clk is much faster than the reference and VCO-divided inputs
`timescale 1ns/1ps
`default_nettype none

module pll_divider_lock_control
  import pll_lock_pkg::*;
(
  input wire logic clk, // 100 MHz system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic refOscIn, // reference oscillator square wave
  input wire logic vcoIn, // prescaled VCO signal
  input wire logic [1:0] refSelectA, // first select pin level code
  input wire logic [1:0] refSelectB, // second select pin level code
  input wire logic [1:0] loopControlPin, // control pin level code
  input wire logic powerSavePin, // power save request
  output pll_lock_pkg::pump_cmd_type pumpOutput, // pump source and sink enables
  output logic [1:0] pumpCurrent, // pump current code
  output logic filterAmpInputGround, // ground the filter amplifier input
  output logic dividerTestOut, // selected divider monitor
  output logic lockIndicatorOut, // open collector data, always low
  output logic lockIndicatorOe, // high while pulling the lock pin low
  output logic analogPowerSave, // power save to the analog path only
  output logic [6:0] refDivideFactor // reference factor in use
);
  import pll_lock_pkg::*;

  function automatic logic [1:0] levelOf(input logic [1:0] code);
    levelOf = (code == 2'h3) ? LVL_OPEN : code;
  endfunction

  function automatic logic [6:0] refFactorOf(input logic [1:0] a, input logic [1:0] b);
    logic [3:0] key;
    key = {levelOf(a), levelOf(b)};
    if (key == {LVL_LOW, LVL_OPEN}) refFactorOf = 7'h24;
    else if (key == {LVL_LOW, LVL_HIGH}) refFactorOf = 7'h21;
    else if (key == {LVL_LOW, LVL_LOW}) refFactorOf = 7'h30;
    else if (key == {LVL_OPEN, LVL_OPEN}) refFactorOf = 7'h41;
    else if (key == {LVL_OPEN, LVL_HIGH}) refFactorOf = 7'h3f;
    else if (key == {LVL_OPEN, LVL_LOW}) refFactorOf = 7'h40;
    else if (key == {LVL_HIGH, LVL_OPEN}) refFactorOf = 7'h23;
    else if (key == {LVL_HIGH, LVL_HIGH}) refFactorOf = 7'h20;
    else refFactorOf = 7'h31;
  endfunction

  // three-stage synchroniser; a change counts once stages two and three agree
  logic [PIN_WIDTH-1:0] sync1, sync2, sync3, pins, pinsPrev;
  logic [PIN_WIDTH-1:0] next_pins;

  always_comb
  begin
    next_pins = (sync2 & sync3) | (pins & (sync2 ^ sync3));
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sync1 <= PINS_RESET;
      sync2 <= PINS_RESET;
      sync3 <= PINS_RESET;
      pins <= PINS_RESET;
      pinsPrev <= PINS_RESET;
    end
    else
    begin
      sync1 <= {loopControlPin, refSelectB, refSelectA, powerSavePin, vcoIn, refOscIn};
      sync2 <= sync1;
      sync3 <= sync2;
      pins <= next_pins;
      pinsPrev <= pins;
    end
  end

  logic refRise, loRise, pumpOn, lockEnable;
  logic [1:0] ctrlLevel;
  logic [6:0] factor;
  logic refSquare, loSquare;

  logic [6:0] refCount, next_refCount;
  logic [11:0] loCount, next_loCount;
  logic refTick, next_refTick, loTick, next_loTick;
  logic up, down, next_up, next_down, compareEvent;
  logic [5:0] phaseCount, next_phaseCount;
  logic [2:0] goodCount, next_goodCount;
  logic locked, next_locked;
  pump_cmd_type next_pump;
  logic [1:0] next_current;
  logic next_ground, next_test, next_psave;
  logic [6:0] next_factor;

  always_comb
  begin
    refRise = pins[BIT_REF] & ~pinsPrev[BIT_REF];
    loRise = pins[BIT_VCO] & ~pinsPrev[BIT_VCO];
    ctrlLevel = pins[CTRL_LO +: 2];
    factor = refFactorOf(pins[SEL_A_LO +: 2], pins[SEL_B_LO +: 2]);
    // a factor change mid-count ends the period early rather than running away
    next_refCount = refCount;
    next_refTick = 1'b0;
    if (refRise)
    begin
      if (refCount >= factor - 7'h01)
      begin
        next_refCount = REF_COUNT_RESET;
        next_refTick = 1'b1;
      end
      else
        next_refCount = refCount + 7'h01;
    end
    next_loCount = loCount;
    next_loTick = 1'b0;
    if (loRise)
    begin
      if (loCount == LO_DIVIDE_FACTOR - 12'h001)
      begin
        next_loCount = LO_COUNT_RESET;
        next_loTick = 1'b1;
      end
      else
        next_loCount = loCount + 12'h001;
    end
    refSquare = refCount < (factor >> 1);
    loSquare = loCount < LO_HALF;
    // the pump drives the two divided rates to equality
    next_up = up | refTick;
    next_down = down | loTick;
    compareEvent = next_up & next_down;
    if (compareEvent)
    begin
      next_up = 1'b0;
      next_down = 1'b0;
    end
    pumpOn = (ctrlLevel == CTRL_LOW) || (ctrlLevel == CTRL_HIGH);
    lockEnable = pumpOn;
    next_pump.source = next_up & pumpOn;
    next_pump.sink = next_down & pumpOn;
    if (ctrlLevel == CTRL_LOW) next_current = CUR_200UA;
    else if (ctrlLevel == CTRL_HIGH) next_current = CUR_300UA;
    else next_current = CUR_OFF;
    next_ground = (ctrlLevel == CTRL_OPEN);
    if (ctrlLevel == CTRL_HALF) next_test = loSquare;
    else if (ctrlLevel == CTRL_OPEN) next_test = refSquare;
    else next_test = 1'b0;
    // the width of the lone pulse measures the phase difference
    next_phaseCount = PHASE_COUNT_RESET;
    if (!compareEvent && (up ^ down) && phaseCount != 6'h3f)
      next_phaseCount = phaseCount + 6'h01;
    next_goodCount = goodCount;
    if (!lockEnable)
      next_goodCount = GOOD_COUNT_RESET;
    else if (compareEvent)
    begin
      if (phaseCount < LOCK_WINDOW_CYCLES && goodCount != LOCK_GOOD_COUNT)
        next_goodCount = goodCount + 3'h1;
      else if (phaseCount >= LOCK_WINDOW_CYCLES)
        next_goodCount = GOOD_COUNT_RESET;
    end
    next_locked = (next_goodCount == LOCK_GOOD_COUNT);
    next_psave = pins[BIT_PSAVE];
    next_factor = factor;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      refCount <= REF_COUNT_RESET;
      loCount <= LO_COUNT_RESET;
      refTick <= 1'b0;
      loTick <= 1'b0;
      up <= 1'b0;
      down <= 1'b0;
      phaseCount <= PHASE_COUNT_RESET;
      goodCount <= GOOD_COUNT_RESET;
      locked <= 1'b0;
      pumpOutput <= '0;
      pumpCurrent <= CUR_OFF;
      filterAmpInputGround <= 1'b0;
      dividerTestOut <= 1'b0;
      analogPowerSave <= 1'b0;
      refDivideFactor <= FACTOR_RESET;
    end
    else
    begin
      refCount <= next_refCount;
      loCount <= next_loCount;
      refTick <= next_refTick;
      loTick <= next_loTick;
      up <= next_up;
      down <= next_down;
      phaseCount <= next_phaseCount;
      goodCount <= next_goodCount;
      locked <= next_locked;
      pumpOutput <= next_pump;
      pumpCurrent <= next_current;
      filterAmpInputGround <= next_ground;
      dividerTestOut <= next_test;
      analogPowerSave <= next_psave;
      refDivideFactor <= next_factor;
    end
  end

  // open collector: pull low while locked, the external pull-up gives the high
  assign lockIndicatorOut = 1'b0;
  assign lockIndicatorOe = locked;

  AST_REF_TICK: assert property (@(posedge clk) disable iff (!nrst)
    refRise && refCount == factor - 7'h01 |=> refTick && refCount == 7'h00)
    else $error("reference divider missed its terminal count");
  AST_FACTOR_32: assert property (@(posedge clk) disable iff (!nrst)
    pins[SEL_A_LO +: 2] == LVL_HIGH && pins[SEL_B_LO +: 2] == LVL_HIGH |=> refDivideFactor == 7'h20)
    else $error("high/high select did not give factor 32");
  AST_LO_TICK: assert property (@(posedge clk) disable iff (!nrst)
    loRise && loCount == 12'h99f |=> loTick && loCount == 12'h000)
    else $error("LO divider did not wrap at 2464");
  AST_PUMP_SOURCE: assert property (@(posedge clk) disable iff (!nrst)
    refTick && !up && !down && !loTick && pumpOn |=> pumpOutput.source && !pumpOutput.sink)
    else $error("leading reference edge did not source");
  AST_CURRENT_LOW: assert property (@(posedge clk) disable iff (!nrst)
    ctrlLevel == CTRL_LOW |=> pumpCurrent == CUR_200UA)
    else $error("control low did not select 200 uA");
  AST_HALF_OFF: assert property (@(posedge clk) disable iff (!nrst)
    ctrlLevel == CTRL_HALF |=> pumpCurrent == CUR_OFF && pumpOutput == '0 && dividerTestOut == $past(loSquare))
    else $error("half supply control did not stop pump or route LO divider");
  AST_OPEN_TEST: assert property (@(posedge clk) disable iff (!nrst)
    ctrlLevel == CTRL_OPEN |=> dividerTestOut == $past(refSquare) && filterAmpInputGround)
    else $error("open control did not route reference divider or ground filter");
  AST_LOCK_RISE: assert property (@(posedge clk) disable iff (!nrst)
    $rose(locked) |-> goodCount == 3'h7 && $past(compareEvent) && $past(phaseCount) < LOCK_WINDOW_CYCLES)
    else $error("lock raised without seven good comparisons");
  AST_LOCK_DISABLED: assert property (@(posedge clk) disable iff (!nrst)
    !lockEnable |=> !locked && goodCount == 3'h0)
    else $error("lock detector active while disabled");
  AST_BAD_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
    compareEvent && lockEnable && phaseCount >= LOCK_WINDOW_CYCLES |=> goodCount == 3'h0 && !locked)
    else $error("out-of-window comparison did not clear lock");
  AST_PSAVE_PASS: assert property (@(posedge clk) disable iff (!nrst)
    $rose(pins[BIT_PSAVE]) |=> analogPowerSave ##0 $stable(loCount) || loTick || $past(loRise))
    else $error("power save disturbed synthesizer logic");

endmodule

`default_nettype wire

// ==== pll_lock_pkg.sv ====
// constants and types shared by the synthesizer divider and lock logic
// assumes pad comparators resolve the three- and four-level pins into 2-bit codes
package pll_lock_pkg;

  // three-level select pin codes from the pad comparators
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_OPEN = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // four-level loop control pin codes
  localparam logic [1:0] CTRL_LOW = 2'h0;
  localparam logic [1:0] CTRL_HALF = 2'h1;
  localparam logic [1:0] CTRL_OPEN = 2'h2;
  localparam logic [1:0] CTRL_HIGH = 2'h3;

  // pump current codes handed to the analog pump
  localparam logic [1:0] CUR_200UA = 2'h0;
  localparam logic [1:0] CUR_300UA = 2'h1;
  localparam logic [1:0] CUR_OFF = 2'h2;

  // positions of the raw pin inputs in the synchroniser vector
  localparam int PIN_WIDTH = 9;
  localparam int BIT_REF = 0;
  localparam int BIT_VCO = 1;
  localparam int BIT_PSAVE = 2;
  localparam int SEL_A_LO = 3;
  localparam int SEL_B_LO = 5;
  localparam int CTRL_LO = 7;

  localparam logic [11:0] LO_DIVIDE_FACTOR = 12'h9a0;
  localparam logic [11:0] LO_HALF = 12'h4d0;

  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCK_WINDOW_NS = 250;
  localparam logic [5:0] LOCK_WINDOW_CYCLES = 6'(LOCK_WINDOW_NS / CLK_PERIOD_NS);
  localparam logic [2:0] LOCK_GOOD_COUNT = 3'h7;

  // reset values
  localparam logic [PIN_WIDTH-1:0] PINS_RESET = 9'h0a8;
  localparam logic [6:0] REF_COUNT_RESET = 7'h00;
  localparam logic [11:0] LO_COUNT_RESET = 12'h000;
  localparam logic [5:0] PHASE_COUNT_RESET = 6'h00;
  localparam logic [2:0] GOOD_COUNT_RESET = 3'h0;
  localparam logic [6:0] FACTOR_RESET = 7'h00;

  typedef struct packed {
    logic source;
    logic sink;
  } pump_cmd_type;

endpackage

// ==== pll_loop_model.sv ====
// behavioural reference crystal and prescaled vco driving the divider inputs
// assumes the bench holds run low until the select pins have settled on factor 32
`timescale 1ns/1ps
`default_nettype none

module pll_loop_model #(
  parameter int REF_HALF = 231,
  parameter int VCO_HALF = 3,
  parameter int REF_START = 454
)(
  input wire logic clk, // system clock
  input wire logic run, // start both oscillators
  input wire logic holdRef, // freeze reference phase
  input wire logic holdVco, // freeze vco phase
  output logic refOsc, // reference square wave
  output logic vcoOut // prescaled vco square wave
);
  int refPhase = 0;
  int vcoPhase = 0;

  // not a closed loop: phase only moves when the bench freezes one side
  always @(negedge clk)
  begin
    if (run && !holdRef)
      refPhase <= refPhase + 1;
    if (run && !holdVco)
      vcoPhase <= vcoPhase + 1;
  end

  // 2464 vco periods equal 32 reference periods, ref edge 5 cycles ahead
  assign refOsc = run && refPhase >= REF_START &&
    ((refPhase + 2 * REF_HALF - REF_START) % (2 * REF_HALF)) < REF_HALF;
  assign vcoOut = run && (vcoPhase % (2 * VCO_HALF)) >= VCO_HALF;
endmodule

`default_nettype wire

// ==== pll_divider_lock_control_tb.sv ====
// self-checking bench for the synthesizer divider and lock logic
// assumes the loop model as far side; pins change at the falling clock edge
`timescale 1ns/1ps
`default_nettype none

module pll_divider_lock_control_tb;
  import pll_lock_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic run = 1'b0;
  logic holdRef = 1'b0;
  logic holdVco = 1'b0;
  logic refOscIn;
  logic vcoIn;
  logic [1:0] refSelectA = LVL_HIGH;
  logic [1:0] refSelectB = LVL_HIGH;
  logic [1:0] loopControlPin = CTRL_OPEN;
  logic powerSavePin = 1'b0;
  pump_cmd_type pumpOutput;
  logic [1:0] pumpCurrent;
  logic ground;
  logic testOut;
  logic lockOut;
  logic lockOe;
  logic analogSave;
  logic [6:0] factor;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int srcLen = 0;
  int lastWidth = 0;
  int srcFalls = 0;
  int base;
  int t1;
  logic sawSink = 1'b0;
  int tab [9] = '{36, 33, 48, 65, 63, 64, 35, 32, 49};

  always #5 clk = ~clk;
  always @(posedge clk) cyc++;

  pll_loop_model i_model (.clk(clk), .run(run), .holdRef(holdRef), .holdVco(holdVco),
    .refOsc(refOscIn), .vcoOut(vcoIn));

  pll_divider_lock_control i_dut (.clk(clk), .nrst(nrst), .refOscIn(refOscIn), .vcoIn(vcoIn),
    .refSelectA(refSelectA), .refSelectB(refSelectB), .loopControlPin(loopControlPin),
    .powerSavePin(powerSavePin), .pumpOutput(pumpOutput), .pumpCurrent(pumpCurrent),
    .filterAmpInputGround(ground), .dividerTestOut(testOut), .lockIndicatorOut(lockOut),
    .lockIndicatorOe(lockOe), .analogPowerSave(analogSave), .refDivideFactor(factor));

  // source pulse widths in cycles, counted when a pulse ends
  always @(negedge clk)
  begin
    if (pumpOutput.sink === 1'b1)
      sawSink = 1'b1;
    if (pumpOutput.source === 1'b1)
      srcLen++;
    else if (srcLen != 0)
    begin
      lastWidth = srcLen;
      srcLen = 0;
      srcFalls++;
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic probe(input int sel);
    case (sel)
      0: return lockOe;
      1: return testOut;
      default: return pumpOutput.sink;
    endcase
  endfunction

  task automatic waitFor(input int sel, input logic lvl, input int limit);
    int k = 0;
    while (probe(sel) !== lvl && k < limit)
    begin
      @(negedge clk);
      k++;
    end
    if (probe(sel) !== lvl)
    begin
      n_fail++;
      $display("mismatch at %0t: wait ran out, seen %h expected %h", $time, probe(sel), lvl);
      summarize();
    end
  endtask

  initial
  begin
    repeat (12) @(negedge clk);
    check(pumpCurrent, CUR_OFF);
    check(lockOe, 1'b0);
    nrst = 1'b1;
    // select codes 0..2 line up with low/open/high, so the table index encodes both pins
    for (int i = 0; i < 9; i++)
    begin
      refSelectA = 2'(i / 3);
      refSelectB = 2'((i % 3 + 1) % 3);
      repeat (6) @(negedge clk);
      check(factor, 16'(tab[i]));
    end
    refSelectA = LVL_HIGH;
    refSelectB = LVL_HIGH;
    repeat (6) @(negedge clk);
    check(factor, 16'h20);
    // step n to n+1 and back, as a controller would against spurious tones
    refSelectA = LVL_LOW;
    repeat (6) @(negedge clk);
    check(factor, 16'h21);
    refSelectA = LVL_HIGH;
    repeat (6) @(negedge clk);
    check(factor, 16'h20);
    $display("test select table done");
    loopControlPin = CTRL_OPEN;
    run = 1'b1;
    repeat (6) @(negedge clk);
    check(ground, 1'b1);
    check(lockOe, 1'b0);
    waitFor(1, ~testOut, 16000);
    $display("test open control done");
    loopControlPin = CTRL_HALF;
    repeat (6) @(negedge clk);
    base = srcFalls;
    check(pumpCurrent, CUR_OFF);
    check(ground, 1'b0);
    waitFor(1, 1'b0, 16000);
    waitFor(1, 1'b1, 16000);
    t1 = cyc;
    waitFor(1, 1'b0, 16000);
    waitFor(1, 1'b1, 16000);
    check(16'(cyc - t1), 16'd14784);
    check(16'(srcFalls - base), 16'h0);
    $display("test half control done");
    repeat (100) @(negedge clk);
    loopControlPin = CTRL_HIGH;
    powerSavePin = 1'b1;
    repeat (6) @(negedge clk);
    base = srcFalls;
    check(pumpCurrent, CUR_300UA);
    check(testOut, 1'b0);
    check(analogSave, 1'b1);
    waitFor(0, 1'b1, 140000);
    // let the pulse monitor count the last fall before reading its totals
    @(negedge clk);
    check(lockOut, 1'b0);
    check(16'(srcFalls - base), 16'h7);
    check(16'(lastWidth), 16'h5);
    check(sawSink, 1'b0);
    loopControlPin = CTRL_LOW;
    powerSavePin = 1'b0;
    repeat (6) @(negedge clk);
    check(pumpCurrent, CUR_200UA);
    check(lockOe, 1'b1);
    check(analogSave, 1'b0);
    $display("test lock done");
    // vco lags by 45 cycles, beyond the 25 cycle window
    holdVco = 1'b1;
    repeat (40) @(negedge clk);
    holdVco = 1'b0;
    waitFor(0, 1'b0, 32000);
    @(negedge clk);
    check(16'(lastWidth), 16'd45);
    // reference now trails by 15 cycles, so the pump must sink
    holdRef = 1'b1;
    repeat (60) @(negedge clk);
    holdRef = 1'b0;
    waitFor(2, 1'b1, 32000);
    check(pumpOutput.source, 1'b0);
    repeat (30) @(negedge clk);
    check(lockOe, 1'b0);
    $display("test phase error done");
    summarize();
  end
endmodule

`default_nettype wire
